// >>> inc/sbt_pkg.sv
// Operation
// - Two test pins select four modes.
// - Test mode gates clocks of other subcircuits.
// - Test mode routes internal nodes to pads.
// - Eleven of 28 inputs double as test inputs.
// - Sixteen outputs fed via three 2:1 stages.
// - Each output pin has exactly one source.
// - Normal: host reads receive RAM, shifter writes.
// - Receive RAM test forces host address.
// - Receive RAM test: eight bidirectional data muxes.
// - Normal: FIFO address from write/read counter.
// - FIFO test: address comes from input pins.
// - FIFO test: host writes, serial readback only.
// - Transmit FIFO is 64 words of 18 bits.
// - Receive RAM single port, time multiplexed.
package sbt_pkg;
    typedef enum logic [1:0] {
        SBT_NORMAL   = 2'b00,
        SBT_FIFO_TST = 2'b01,
        SBT_RXRAM_TST = 2'b11,
        SBT_SHIFT_TST = 2'b10
    } sbt_mode_e;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW    = 6;
    localparam int FIFO_DW    = 18;
    localparam int RX_DEPTH   = 1024;
    localparam int RX_AW      = 10;
    localparam int RX_DW      = 8;
    localparam int TBUS_W     = 16;
    localparam int TIN_W      = 11;
    localparam logic [1:0] PIN_NORMAL = 2'b00;
    localparam logic [1:0] PIN_FIFO   = 2'b01;
    localparam logic [1:0] PIN_RXRAM  = 2'b10;
    localparam logic [1:0] PIN_SHIFT  = 2'b11;
endpackage

// >>> core/sbt_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; a change counts once stages two and three agree.
module sbt_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         clock,
    input  wire logic         nrst,
    // Pin in, filtered value out.
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] value
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Stage one is read only by stage two to keep metastability contained.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a new value only when the last two stages agree.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            value <= '0;
        end else if (s2 == s3) begin
            value <= s3;
        end
    end
endmodule // sbt_sync

// >>> core/sbt_test_ctrl.sv
`timescale 1ns/10ps
// Serial bus controller datapath with its test-mode partitioning.
module sbt_test_ctrl (
    // Clock and reset.
    input  wire logic                          clock,
    input  wire logic                          nrst,
    // Test mode pins.
    input  wire logic [1:0]                    test_pins,
    // Eleven shared inputs used as test inputs.
    input  wire logic [sbt_pkg::TIN_W-1:0]     test_in,
    // Host bus.
    input  wire logic [sbt_pkg::RX_AW-1:0]     host_addr,
    input  wire logic [sbt_pkg::RX_DW-1:0]     host_wdata,
    input  wire logic                          host_fifo_wr,
    input  wire logic                          host_ram_wr,
    input  wire logic                          host_ram_rd,
    output logic      [sbt_pkg::RX_DW-1:0]     host_rdata,
    output logic                               host_rdata_oe,
    // Serial link.
    input  wire logic                          serial_in,
    output logic                               serial_out,
    // Sixteen outputs that double as the test bus.
    output logic      [sbt_pkg::TBUS_W-1:0]    out_pins,
    output logic      [1:0]                    mode_out
);
    import sbt_pkg::*;

    sbt_mode_e                mode;
    logic [1:0]               pins_q;
    logic [TIN_W-1:0]         tin_q;
    logic                     sin_q;
    logic [FIFO_DW-1:0]       fifo_mem [FIFO_DEPTH];
    logic [RX_DW-1:0]         rx_mem [RX_DEPTH];
    logic [FIFO_AW-1:0]       wr_cnt;
    logic [FIFO_AW-1:0]       rd_cnt;
    logic [FIFO_AW:0]         fill;
    logic [FIFO_DW-1:0]       tx_shift;
    logic [4:0]               tx_bits;
    logic [RX_DW-1:0]         rx_shift;
    logic [2:0]               rx_bits;
    logic [RX_AW-1:0]         rx_wptr;
    logic                     rx_ready;
    logic [RX_DW-1:0]         rx_byte;
    logic [FIFO_DW-1:0]       fifo_q;
    logic [FIFO_AW-1:0]       fifo_addr;
    logic [RX_AW-1:0]         rx_addr;
    logic                     en_fifo;
    logic                     en_shift;
    logic                     en_rx;
    logic [TBUS_W-1:0]        tbus;
    logic [TBUS_W-1:0]        stage1;
    logic [TBUS_W-1:0]        stage2;
    logic [TBUS_W-1:0]        stage3;
    logic [TBUS_W-1:0]        normal_out;

    // Decode a pin code into a mode.
    function automatic sbt_mode_e decode_mode(input logic [1:0] p);
        case (p)
            PIN_FIFO:  return SBT_FIFO_TST;
            PIN_RXRAM: return SBT_RXRAM_TST;
            PIN_SHIFT: return SBT_SHIFT_TST;
            default:   return SBT_NORMAL;
        endcase
    endfunction

    // Test pins cross in from the tester, so they are synchronised.
    sbt_sync #(.W(2)) u_pin_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (test_pins),
        .value (pins_q)
    );
    sbt_sync #(.W(TIN_W)) u_tin_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (test_in),
        .value (tin_q)
    );
    sbt_sync #(.W(1)) u_sin_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (serial_in),
        .value (sin_q)
    );

    // Mode register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode <= SBT_NORMAL;
        end else begin
            mode <= decode_mode(pins_q);
        end
    end

    // Subcircuit enables stand in for gated clocks; a real gate would glitch in FPGA flows.
    assign en_fifo  = (mode == SBT_NORMAL) || (mode == SBT_FIFO_TST);
    assign en_shift = (mode == SBT_NORMAL) || (mode == SBT_SHIFT_TST);
    assign en_rx    = (mode == SBT_NORMAL) || (mode == SBT_RXRAM_TST);

    // FIFO address: counters normally, pins in FIFO test.
    assign fifo_addr = (mode == SBT_FIFO_TST) ? tin_q[FIFO_AW-1:0]
                     : (host_fifo_wr ? wr_cnt : rd_cnt);
    assign fifo_q = fifo_mem[fifo_addr];

    // Transmit FIFO storage; a normal write into a full FIFO is dropped so unread words survive.
    always_ff @(posedge clock) begin
        if (en_fifo && host_fifo_wr && (mode == SBT_FIFO_TST || fill != 7'(FIFO_DEPTH))) begin
            fifo_mem[fifo_addr] <= {host_addr[FIFO_DW-RX_DW-1:0], host_wdata};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_cnt <= '0;
            rd_cnt <= '0;
            fill   <= '0;
        end else if (en_fifo && mode == SBT_NORMAL) begin
            if (host_fifo_wr && fill != 7'(FIFO_DEPTH)) begin
                wr_cnt <= wr_cnt + 6'h01;
            end
            if (tx_bits == 5'h00 && fill != 7'h00 && !host_fifo_wr) begin
                rd_cnt <= rd_cnt + 6'h01;
            end
            fill <= fill + 7'(host_fifo_wr && fill != 7'(FIFO_DEPTH))
                         - 7'(tx_bits == 5'h00 && fill != 7'h00 && !host_fifo_wr);
        end
    end

    // Output shifter: loads a FIFO word, or in FIFO test any addressed word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_shift <= '0;
            tx_bits  <= '0;
        end else if (en_shift || mode == SBT_FIFO_TST) begin
            if (tx_bits != 5'h00) begin
                tx_shift <= {tx_shift[FIFO_DW-2:0], 1'b0};
                tx_bits  <= tx_bits - 5'h01;
            end else if (!host_fifo_wr && (fill != 7'h00 || mode == SBT_FIFO_TST)) begin
                tx_shift <= fifo_q;
                tx_bits  <= 5'(FIFO_DW);
            end
        end
    end

    // Receive RAM address: host in test mode or on a host read, else shifter.
    assign rx_addr = (mode == SBT_RXRAM_TST || host_ram_rd) ? host_addr : rx_wptr;

    // Receive shifter assembles bytes from the line.
    // A finished byte is held apart, since the shifter keeps moving while a host read
    // owns the RAM slot; a read that holds the slot for the seven cycles after a byte completes loses it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_shift <= '0;
            rx_bits  <= '0;
            rx_ready <= 1'b0;
            rx_byte  <= '0;
            rx_wptr  <= '0;
        end else if (en_shift && mode != SBT_RXRAM_TST) begin
            rx_shift <= {rx_shift[RX_DW-2:0], sin_q};
            rx_bits  <= rx_bits + 3'h1;
            if (rx_bits == 3'h7) begin
                rx_ready <= 1'b1;
                rx_byte  <= {rx_shift[RX_DW-2:0], sin_q};
            end else if (rx_ready && !host_ram_rd) begin
                rx_ready <= 1'b0;
                rx_wptr  <= rx_wptr + 10'h001;
            end
        end
    end

    // Single-port receive RAM; host read wins the slot, the shifter waits.
    always_ff @(posedge clock) begin
        if (en_rx) begin
            if (mode == SBT_RXRAM_TST && host_ram_wr) begin
                rx_mem[rx_addr] <= host_wdata;
            end else if (mode == SBT_NORMAL && rx_ready && !host_ram_rd) begin
                rx_mem[rx_addr] <= rx_byte;
            end
        end
    end

    // Host read data is registered and driven only during a read.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_rdata    <= '0;
            host_rdata_oe <= 1'b0;
        end else begin
            host_rdata    <= rx_mem[rx_addr];
            host_rdata_oe <= host_ram_rd && en_rx;
        end
    end

    // Test bus nodes per mode, then three cascaded 2:1 stages.
    assign normal_out = {8'h00, rx_shift};
    assign stage1 = (mode == SBT_FIFO_TST)  ? {4'h0, fill[FIFO_AW-1:0], wr_cnt} : normal_out;
    assign stage2 = (mode == SBT_RXRAM_TST) ? {6'h00, rx_addr} : stage1;
    assign stage3 = (mode == SBT_SHIFT_TST) ? {tx_bits, rx_bits, rx_shift} : stage2;
    assign tbus   = stage3;

    // Pads are registered so every output comes from a flip-flop.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_pins   <= '0;
            serial_out <= 1'b0;
            mode_out   <= 2'b00;
        end else begin
            out_pins   <= tbus;
            serial_out <= tx_shift[FIFO_DW-1];
            mode_out   <= pins_q;
        end
    end

    rx_bypass_a: assert property (@(posedge clock) disable iff (!nrst)
        mode == SBT_RXRAM_TST |-> rx_addr == host_addr)
        else $error("Receive RAM address not from host in test.");
    fifo_pin_addr_a: assert property (@(posedge clock) disable iff (!nrst)
        mode == SBT_FIFO_TST |-> fifo_addr == tin_q[FIFO_AW-1:0])
        else $error("FIFO address not from pins in test.");
    clock_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        mode == SBT_FIFO_TST |=> $stable(rx_bits) || mode != SBT_FIFO_TST)
        else $error("Shifter ran while gated.");
    mode_decode_a: assert property (@(posedge clock) disable iff (!nrst)
        ##1 mode == decode_mode($past(pins_q)))
        else $error("Mode does not follow pins.");
    test_bus_a: assert property (@(posedge clock) disable iff (!nrst)
        mode == SBT_SHIFT_TST |=> out_pins == $past(stage3))
        else $error("Test bus not on pads.");
    one_source_a: assert property (@(posedge clock) disable iff (!nrst)
        ##1 out_pins == $past(tbus))
        else $error("Pad driven by wrong source.");
    rx_no_shift_a: assert property (@(posedge clock) disable iff (!nrst)
        mode == SBT_RXRAM_TST ##1 mode == SBT_RXRAM_TST |-> $stable(rx_shift))
        else $error("Receive shifter active in RAM test.");
    fifo_count_a: assert property (@(posedge clock) disable iff (!nrst)
        fill <= 7'(FIFO_DEPTH))
        else $error("FIFO fill beyond depth.");
endmodule // sbt_test_ctrl

// >>> dv/sbt_serial_src.sv
`timescale 1ns/10ps
// Far-side serial source that feeds the receive shifter.
module sbt_serial_src (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic nrst,
    // Run request from the bench, serial line out.
    input  wire logic active,
    output logic      serial_in
);
    // Toggle every cycle while active; stages two and three of the core's synchroniser then never agree, so its value holds.
    // The line idles high, as a released serial line with pull-up does.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serial_in <= 1'b1;
        end else if (active) begin
            serial_in <= ~serial_in;
        end else begin
            serial_in <= 1'b1;
        end
    end
endmodule // sbt_serial_src

// >>> dv/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the test-mode partitioning.
module tb;
    import sbt_pkg::*;
    logic              clock;
    logic              nrst;
    logic [1:0]        test_pins;
    logic [TIN_W-1:0]  test_in;
    logic [RX_AW-1:0]  host_addr;
    logic [RX_DW-1:0]  host_wdata;
    logic              host_fifo_wr;
    logic              host_ram_wr;
    logic              host_ram_rd;
    logic [RX_DW-1:0]  host_rdata;
    logic              host_rdata_oe;
    logic              serial_in;
    logic              serial_out;
    logic [TBUS_W-1:0] out_pins;
    logic [1:0]        mode_out;
    logic              ser_active;
    int                fail_count;
    int                comparisons;

    sbt_test_ctrl uut (.clock(clock), .nrst(nrst), .test_pins(test_pins),
        .test_in(test_in), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_fifo_wr(host_fifo_wr), .host_ram_wr(host_ram_wr),
        .host_ram_rd(host_ram_rd), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe), .serial_in(serial_in),
        .serial_out(serial_out), .out_pins(out_pins), .mode_out(mode_out));

    sbt_serial_src far (.clock(clock), .nrst(nrst), .active(ser_active),
        .serial_in(serial_in));

    // Free-running 200 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Compare any result up to a FIFO word wide.
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic test_done();
        $display("Checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Pins pass a three-flop filter, so allow eight cycles to settle.
    task automatic set_mode(input logic [1:0] m);
        @(posedge clock) test_pins <= m;
        repeat (8) @(posedge clock);
        #1 chk(18'(mode_out), 18'(m), "mode");
    endtask

    task automatic ram_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock) begin
            host_addr   <= a;
            host_wdata  <= d;
            host_ram_wr <= 1'b1;
        end
        @(posedge clock) host_ram_wr <= 1'b0;
    endtask

    task automatic ram_rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clock) begin
            host_addr   <= a;
            host_ram_rd <= 1'b1;
        end
        @(posedge clock) host_ram_rd <= 1'b0;
        #1 chk(18'(host_rdata), 18'(exp), "ram data");
        chk(18'(host_rdata_oe), 18'h1, "rdata enable");
    endtask

    // The test bus and read enable idle low and the mode is normal after reset.
    task automatic t_reset();
        chk(18'(out_pins), 18'h0, "bus at reset");
        chk(18'(mode_out), 18'(PIN_NORMAL), "mode at reset");
        chk(18'(host_rdata_oe), 18'h0, "oe at reset");
    endtask

    // Walk all four pin codes.
    task automatic t_modes();
        set_mode(PIN_FIFO);
        set_mode(PIN_RXRAM);
        set_mode(PIN_SHIFT);
        set_mode(PIN_NORMAL);
    endtask

    // Host reaches both ends of the receive RAM while serial traffic runs.
    task automatic t_ram_test();
        logic first;
        set_mode(PIN_RXRAM);
        ser_active <= 1'b1;
        ram_wr(10'h000, 8'ha5);
        ram_wr(10'h3ff, 8'h5a);
        ram_rd(10'h000, 8'ha5);
        ram_rd(10'h3ff, 8'h5a);
        repeat (3) @(posedge clock);
        #1 chk(18'(out_pins), 18'h003ff, "ram test bus");
        first = serial_out;
        // The transmit shifter is gated off, so its output must not move.
        for (int i = 0; i < 20; i++) begin
            @(posedge clock);
            #1 chk(18'(serial_out), 18'(first), "gated shifter");
        end
        ser_active <= 1'b0;
    endtask

    // Outside the RAM test the host write strobe is refused.
    // The idle line fills the receive shifter with ones, seen on the normal bus.
    task automatic t_normal();
        set_mode(PIN_NORMAL);
        ram_wr(10'h3ff, 8'h11);
        ram_rd(10'h3ff, 8'h5a);
        chk(18'(out_pins), 18'h000ff, "normal bus");
    endtask

    // Collect serial bits for a bounded time until the word has gone by.
    task automatic ser_find(input logic [17:0] w, output logic found);
        logic [17:0] sh;
        sh = 18'h0;
        found = 1'b0;
        for (int i = 0; i < 120 && !found; i++) begin
            @(posedge clock);
            #1 sh = {sh[16:0], serial_out};
            found = (sh === w);
        end
    endtask

    // Two words written back to back in normal mode leave in the order written.
    task automatic t_fifo_normal();
        logic found;
        @(posedge clock) begin
            host_addr    <= 10'h2b3;
            host_wdata   <= 8'h4c;
            host_fifo_wr <= 1'b1;
        end
        @(posedge clock) begin
            host_addr  <= 10'h154;
            host_wdata <= 8'hb3;
        end
        @(posedge clock) host_fifo_wr <= 1'b0;
        ser_find(18'h2b34c, found);
        chk(18'(found), 18'h1, "first fifo word");
        ser_find(18'h154b3, found);
        chk(18'(found), 18'h1, "second fifo word");
    endtask

    // Random FIFO access from the pins, read back only through the shifter.
    task automatic t_fifo();
        logic [5:0]  ad[3] = '{6'h3f, 6'h00, 6'h3f};
        logic [17:0] wd[3] = '{18'h2b34c, 18'h154b3, 18'h2b34c};
        logic        found;
        set_mode(PIN_FIFO);
        // Two normal writes left the write counter at two and the FIFO empty.
        chk(18'(out_pins), 18'h00002, "fifo test bus");
        for (int k = 0; k < 3; k++) begin
            @(posedge clock) test_in <= {5'h00, ad[k]};
            repeat (6) @(posedge clock);
            if (k < 2) begin
                @(posedge clock) begin
                    host_addr    <= wd[k][17:8];
                    host_wdata   <= wd[k][7:0];
                    host_fifo_wr <= 1'b1;
                end
                @(posedge clock) host_fifo_wr <= 1'b0;
            end
            ser_find(wd[k], found);
            chk(18'(found), 18'h1, "fifo word serial");
        end
    endtask

    initial begin
        nrst         = 1'b0;
        test_pins    = PIN_NORMAL;
        test_in      = '0;
        host_addr    = '0;
        host_wdata   = '0;
        host_fifo_wr = 1'b0;
        host_ram_wr  = 1'b0;
        host_ram_rd  = 1'b0;
        ser_active   = 1'b0;
        fail_count   = 0;
        comparisons  = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        #1 t_reset();
        t_modes();
        t_fifo_normal();
        t_fifo();
        t_ram_test();
        t_normal();
        test_done();
    end
endmodule // tb
